//--- tb/spc_core_model.sv
/* spc_core_model: processor core side, writes control and sleeps.
   assumes: tasks are entered just after a rising clock edge. */
`timescale 1ns/10ps
`default_nettype none
module spc_core_model (
  input  wire logic       i_sys_clk,
  output logic            o_ctrl_wr,
  output logic [7:0]      o_ctrl_data,
  output logic            o_sleep_instr
);
  initial begin
    o_ctrl_wr = 1'b0;
    o_ctrl_data = 8'h00;
    o_sleep_instr = 1'b0;
  end
  // enable write, then request write gap cycles later
  task automatic brownout_sleep_request_seq(input int gap);
    o_ctrl_wr <= 1'b1;
    o_ctrl_data <= 8'h60;  // request and enable both set
    @(posedge i_sys_clk);
    if (gap > 1) begin
      o_ctrl_wr <= 1'b0;
      o_ctrl_data <= 8'h9f;  // idle data is junk, not the last value
      repeat (gap - 1) @(posedge i_sys_clk);
      o_ctrl_wr <= 1'b1;
    end
    o_ctrl_data <= 8'h40;  // request alone, enable cleared
    @(posedge i_sys_clk);
    o_ctrl_wr <= 1'b0;
    o_ctrl_data <= 8'hbf;
  endtask : brownout_sleep_request_seq
  // one sleep instruction; caller sets the arm bit first
  task automatic sleep_op;
    o_sleep_instr <= 1'b1;
    @(posedge i_sys_clk);
    o_sleep_instr <= 1'b0;
  endtask : sleep_op
endmodule : spc_core_model
`default_nettype wire

//--- tb/spc_sleep_ctrl_sva.sv
/* spc_sleep_ctrl_sva: port checks for the sleep controller.
   assumes: bound to spc_sleep_ctrl, one clock, sync reset. */
`timescale 1ns/10ps
`default_nettype none
module spc_sleep_ctrl_sva
  import spc_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_srst,
  input wire logic       i_ctrl_wr,
  input wire logic [7:0] i_ctrl_data,
  input wire logic [2:0] i_sleep_select_field,
  input wire logic       i_sleep_arm_bit,
  input wire logic       i_sleep_instr,
  input wire logic       i_brownout_fuse_en,
  input wire logic       i_debug_enable_fuse,
  input wire logic       i_adc_enable,
  input wire logic       i_reset_event,
  input wire logic       o_clk_cpu_en,
  input wire logic       o_clk_io_en,
  input wire logic       o_clk_adc_en,
  input wire logic       o_main_osc_en,
  input wire logic       o_brownout_detector_en,
  input wire logic       o_brownout_sleep_request,
  input wire logic       o_adc_start,
  input wire logic       o_comparator_off,
  input wire logic       o_input_buf_off,
  input wire logic       o_sleeping
);
  logic [3:0] en_age_q;  // cycles since the last enable write
  wire logic  go = i_sleep_instr && i_sleep_arm_bit && !o_sleeping
                   && !i_reset_event;  // a sleep the core may take
  // age counter saturates so old enable writes never count again
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) en_age_q <= 4'hf;
    else if (i_ctrl_wr && i_ctrl_data[6:5] == 2'b11) en_age_q <= 4'h0;
    else if (en_age_q != 4'hf) en_age_q <= en_age_q + 4'h1;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence s_enter(logic [2:0] c, logic d);
    go && i_sleep_select_field == c && d;
  endsequence
  sequence s_arm;
    (i_ctrl_wr && i_ctrl_data[6:5] == 2'b11)
    ##[1:4] (i_ctrl_wr && i_ctrl_data[6:5] == 2'b10);
  endsequence
  property p_idle; s_enter(SPC_SEL_IDLE, 1'b1) |-> ##2 !o_clk_cpu_en
    && o_clk_io_en && o_clk_adc_en && !o_comparator_off; endproperty
  a_idle: assert property (p_idle) else $error("idle clocks wrong");
  property p_noise; s_enter(SPC_SEL_ADCNR, 1'b1) |-> ##2 !o_clk_cpu_en
    && !o_clk_io_en && o_clk_adc_en && !o_input_buf_off; endproperty
  a_noise: assert property (p_noise) else $error("noise clocks wrong");
  property p_pdown; s_enter(SPC_SEL_PDOWN, !i_debug_enable_fuse) |-> ##2
    !o_clk_adc_en && !o_main_osc_en && o_comparator_off && o_input_buf_off;
  endproperty
  a_pdown: assert property (p_pdown) else $error("pdown wrong");
  property p_debug; s_enter(SPC_SEL_PDOWN, i_debug_enable_fuse) |-> ##2
    o_main_osc_en && !o_clk_cpu_en; endproperty
  a_debug: assert property (p_debug) else $error("debug osc stopped");
  property p_adc; go && i_sleep_select_field[2:1] == 2'b00 && i_adc_enable
    |-> ##[1:3] o_adc_start; endproperty
  a_adc: assert property (p_adc) else $error("no adc start");
  property p_resv; i_sleep_instr && i_sleep_arm_bit && !o_sleeping &&
    i_sleep_select_field[2:1] == 2'b10 |-> ##2 !o_sleeping && o_clk_cpu_en;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved code slept");
  property p_bod_off; s_enter(SPC_SEL_PDOWN, o_brownout_sleep_request &&
    i_brownout_fuse_en) |-> ##2 !o_brownout_detector_en; endproperty
  a_bod_off: assert property (p_bod_off) else $error("detector on");
  property p_bod_keep; s_enter(SPC_SEL_PDOWN, !o_brownout_sleep_request)
    |-> ##2 o_brownout_detector_en == i_brownout_fuse_en; endproperty
  a_bod_keep: assert property (p_bod_keep) else $error("detector off");
  property p_bod_on; i_brownout_fuse_en && $fell(o_sleeping)
    |-> ##[0:1] o_brownout_detector_en; endproperty
  a_bod_on: assert property (p_bod_on) else $error("detector not back");
  property p_brownout_sleep_request; s_arm |-> ##[2:4] o_brownout_sleep_request [*3]
    ##1 !o_brownout_sleep_request; endproperty
  a_brownout_sleep_request: assert property (p_brownout_sleep_request) else $error("request window wrong");
  property p_late; i_ctrl_wr && i_ctrl_data[6:5] == 2'b10 &&
    en_age_q > 4'h9 && !o_brownout_sleep_request
    |-> ##1 !o_brownout_sleep_request [*6]; endproperty
  a_late: assert property (p_late) else $error("late request taken");
endmodule : spc_sleep_ctrl_sva
bind spc_sleep_ctrl spc_sleep_ctrl_sva spc_sleep_ctrl_sva_inst (
  .i_sys_clk, .i_srst, .i_ctrl_wr, .i_ctrl_data, .i_sleep_select_field,
  .i_sleep_arm_bit, .i_sleep_instr, .i_brownout_fuse_en,
  .i_debug_enable_fuse, .i_adc_enable, .i_reset_event, .o_clk_cpu_en,
  .o_clk_io_en, .o_clk_adc_en, .o_main_osc_en, .o_brownout_detector_en,
  .o_brownout_sleep_request, .o_adc_start, .o_comparator_off,
  .o_input_buf_off, .o_sleeping);
`default_nettype wire

//--- tb/testbench.sv
/* testbench: sleep modes, wake latency, gating and request timing.
   assumes: spc_pkg compiled first; checker bound by its own file. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0, srst = 1'b1, arm = 1'b0, xtal = 1'b1, dbg = 1'b0;
  logic fuse = 1'b1, adc_en = 1'b1, wdt = 1'b1, rst_ev = 1'b0;
  logic t2 = 1'b1, t2a = 1'b1, gie = 1'b1, t2ie = 1'b1;
  logic [2:0] sel = 3'h0;
  logic [8:0] gate = 9'h000;
  logic [9:0] wake = 10'h000;
  wire logic cwr, sins, cpu, io, adc, asy, mosc, det, req, slp;
  wire logic flash, tosc, wrun;
  wire logic [7:0] cdat;
  wire logic [8:0] pclk, pblk;
  logic [8:0] q_dom[$];  // expected domain vectors
  int q_lat[$];          // expected wake delays
  time t_wake;
  bit slp_q, cpu_q, pend;
  int err_total = 0, n_checks = 0;
  always #5 clk = ~clk;
  spc_core_model core_inst (.i_sys_clk(clk), .o_ctrl_wr(cwr),
    .o_ctrl_data(cdat), .o_sleep_instr(sins));
  spc_sleep_ctrl #(.STARTUP_CYC(16'h0010), .BOD_WAKE_CYC(40))
  spc_sleep_ctrl_inst (.i_sys_clk(clk), .i_srst(srst), .i_ctrl_wr(cwr),
    .i_ctrl_data(cdat), .i_sleep_select_field(sel), .i_sleep_arm_bit(arm),
    .i_sleep_instr(sins), .i_peripheral_clock_gate_register(gate),
    .i_ext_crystal(xtal), .i_debug_enable_fuse(dbg),
    .i_brownout_fuse_en(fuse), .i_adc_enable(adc_en), .i_wdt_enable(wdt),
    .i_t2_enable(t2), .i_t2_async(t2a), .i_global_int_en(gie),
    .i_t2_int_en(t2ie), .i_wake_src(wake), .i_reset_event(rst_ev),
    .o_clk_cpu_en(cpu), .o_clk_flash_en(flash), .o_clk_io_en(io),
    .o_clk_adc_en(adc), .o_clk_asy_en(asy), .o_main_osc_en(mosc),
    .o_timer_osc_en(tosc), .o_t2_sync_clk_en(),
    .o_brownout_detector_en(det),
    .o_brownout_sleep_request(req), .o_adc_start(), .o_adc_extended(),
    .o_comparator_off(), .o_input_buf_off(), .o_wdt_run(wrun),
    .o_sleeping(slp), .o_periph_clk_en(pclk), .o_periph_reg_block(pblk));
  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] s);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic lat_chk(input int e, input int s);
    n_checks++;
    if (s < e || s > e + 6) begin
      err_total++;
      $display("unexpected wake latency exp %0d seen %0d", e, s);
    end
  endtask : lat_chk
  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // monitor: domains one cycle after sleep starts, delay when cpu restarts
  always @(posedge clk) begin
    if (pend) chk("domains", q_dom.pop_front(),
      {flash, tosc, det, slp, cpu, io, adc, asy, mosc});
    pend = slp === 1'b1 && !slp_q && q_dom.size() > 0;
    if (cpu === 1'b1 && !cpu_q && q_lat.size() > 0) begin
      lat_chk(q_lat.pop_front(), int'(($time - t_wake) / 10));
      chk("detector", 9'h001, {8'h00, det});
    end
    slp_q = slp === 1'b1;
    cpu_q = cpu === 1'b1;
  end
  // one sleep: e[5] low means the sleep must be refused; bad 10 = none
  task automatic run(input logic [2:0] code, input logic [1:0] opt,
      input bit brownout_sleep_request, input logic [8:0] e, input int good, input int bad,
      input int lat);
    int i;
    sel <= code;
    dbg <= opt[0];
    xtal <= !opt[1];
    fuse <= e[5];
    arm <= 1'b1;
    adc_en <= 1'($urandom);
    wdt <= 1'($urandom);
    @(posedge clk);
    if (e[5]) q_dom.push_back(e);
    if (brownout_sleep_request) begin
      core_inst.brownout_sleep_request_seq(1);
      repeat (3) @(posedge clk);
    end
    core_inst.sleep_op();
    repeat (5) @(negedge clk);
    chk("watchdog run", {8'h00, wdt}, {8'h00, wrun});
    if (!e[5]) chk("refused", 9'h001, {7'h00, slp, cpu});
    else begin
      if (bad < 10) begin
        @(posedge clk);
        wake[bad] <= 1'b1;
        repeat (12) @(negedge clk);
        chk("stray wake", 9'h002, {7'h00, slp, cpu});
        @(posedge clk);
        wake[bad] <= 1'b0;
      end
      @(posedge clk);
      q_lat.push_back(lat);
      wake[good] <= 1'b1;
      t_wake = $time;
      for (i = 0; i < 300 && cpu !== 1'b1; i++) @(posedge clk);
      if (i == 300) begin
        err_total++;
        $display("unexpected wake timeout exp 1 seen %b", cpu);
        results();
      end
      wake[good] <= 1'b0;
    end
    arm <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : run
  initial begin
    void'($urandom(3893));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    repeat (6) begin
      gate <= 9'($urandom); // peripherals idle while gated
      repeat (3) @(negedge clk);
      chk("clock enables", ~gate, pclk);
      chk("register block", gate, pblk);
      @(posedge clk);
    end
    gate <= 9'h000;
    core_inst.brownout_sleep_request_seq(13);
    repeat (5) @(negedge clk);
    chk("late request", 9'h000, {8'h00, req});
    @(posedge clk);
    core_inst.brownout_sleep_request_seq(4);
    repeat (4) @(negedge clk);
    chk("request", 9'h001, {8'h00, req});
    repeat (5) @(negedge clk);
    chk("request cleared", 9'h000, {8'h00, req});
    @(posedge clk);
    run(3'h0, 2'b00, 1'b0, 9'h0ef, 9, 10, 4);
    run(3'h1, 2'b00, 1'b0, 9'h0e7, 0, 9, 4);
    run(3'h2, 2'b00, 1'b0, 9'h060, 7, 0, 20);
    run(3'h3, 2'b00, 1'b0, 9'h0e2, 4, 5, 20);
    run(3'h6, 2'b00, 1'b0, 9'h061, 8, 4, 6);
    run(3'h7, 2'b00, 1'b0, 9'h0e3, 4, 0, 6);
    run(3'h2, 2'b00, 1'b1, 9'h020, 3, 10, 40);
    run(3'h2, 2'b01, 1'b0, 9'h061, 6, 10, 20);
    run(3'h4, 2'b00, 1'b0, 9'h000, 0, 10, 0);
    run(3'h5, 2'b00, 1'b0, 9'h000, 0, 10, 0);
    run(3'h7, 2'b10, 1'b0, 9'h000, 0, 10, 0);
    results();
  end
endmodule : testbench
`default_nettype wire

//--- verilog/spc_pkg.sv
/*
 * spc_pkg: constants shared by the sleep and power controller files.
 * assumes: 100 MHz system clock; no register bus, all bits are plain ports.
 */
package spc_pkg;
  // sleep select codes
  localparam logic [2:0] SPC_SEL_IDLE   = 3'h0;
  localparam logic [2:0] SPC_SEL_ADCNR  = 3'h1;
  localparam logic [2:0] SPC_SEL_PDOWN  = 3'h2;
  localparam logic [2:0] SPC_SEL_PSAVE  = 3'h3;
  localparam logic [2:0] SPC_SEL_STBY   = 3'h6;
  localparam logic [2:0] SPC_SEL_XSTBY  = 3'h7;
  // field position of the brown-out sleep request in the control byte
  localparam int         SPC_BROWNOUT_SLEEP_REQUEST_BIT   = 6;
  localparam int         SPC_BROWNOUT_SLEEP_WRITE_ENABLE_BIT  = 5;
  // timed sequence: window after enable, delay to effect, active length
  localparam logic [2:0] SPC_BROWNOUT_SLEEP_WRITE_ENABLE_WIN  = 3'h4;
  localparam logic [2:0] SPC_BROWNOUT_SLEEP_REQUEST_DLY   = 3'h3;
  localparam logic [2:0] SPC_BROWNOUT_SLEEP_REQUEST_LEN   = 3'h3;
  // wake-up figures
  localparam int         SPC_CLK_MHZ    = 100;
  localparam int         SPC_BOD_WAKE_US = 60;
  localparam int         SPC_BOD_WAKE_CYC = SPC_BOD_WAKE_US * SPC_CLK_MHZ;
  localparam logic [15:0] SPC_STBY_WAKE = 16'h0006;
  localparam logic [15:0] SPC_HALT_EXTRA = 16'h0004;
  // peripheral gate count
  localparam int         SPC_NPER       = 9;
  // wake source vector bit positions
  localparam int W_ADC = 0;   // adc conversion complete
  localparam int W_WDT = 1;   // watchdog interrupt
  localparam int W_TWI = 2;   // two-wire interrupt
  localparam int W_TWA = 3;   // two-wire address match
  localparam int W_T2  = 4;   // timer 2 interrupt
  localparam int W_SPM = 5;   // spm or eeprom ready
  localparam int W_LVL = 6;   // external level interrupt
  localparam int W_EXT = 7;   // external edge interrupt lines 2..0
  localparam int W_PCH = 8;   // pin change
  localparam int W_OTH = 9;   // any other enabled interrupt
  localparam int SPC_NWAKE = 10;
endpackage : spc_pkg

//--- verilog/spc_sleep_ctrl.sv
/*
 * spc_sleep_ctrl: sleep mode and clock gating controller.
 * assumes: the core pulses i_sleep_instr on a sleep instruction, control
 * bytes arrive as write strobes, peripherals obey the gate outputs.
 */
`timescale 1ns/10ps
`default_nettype none
module spc_sleep_ctrl
  import spc_pkg::*;
#(
  parameter int          NPER          = SPC_NPER,
  parameter logic [15:0] STARTUP_CYC   = 16'h0040,  // fuse start-up time
  parameter int          BOD_WAKE_CYC  = SPC_BOD_WAKE_CYC
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_srst,
  input  wire logic            i_ctrl_wr,        // control byte write strobe
  input  wire logic [7:0]      i_ctrl_data,      // control byte data
  input  wire logic [2:0]      i_sleep_select_field,
  input  wire logic            i_sleep_arm_bit,
  input  wire logic            i_sleep_instr,    // sleep executed, pulse
  input  wire logic [NPER-1:0] i_peripheral_clock_gate_register,
  input  wire logic            i_ext_crystal,    // crystal clock option
  input  wire logic            i_debug_enable_fuse,
  input  wire logic            i_brownout_fuse_en,
  input  wire logic            i_adc_enable,
  input  wire logic            i_wdt_enable,
  input  wire logic            i_t2_enable,
  input  wire logic            i_t2_async,
  input  wire logic            i_global_int_en,
  input  wire logic            i_t2_int_en,
  input  wire logic [SPC_NWAKE-1:0] i_wake_src,
  input  wire logic            i_reset_event,    // ext, wdt or brown-out
  output logic                 o_clk_cpu_en,
  output logic                 o_clk_flash_en,
  output logic                 o_clk_io_en,
  output logic                 o_clk_adc_en,
  output logic                 o_clk_asy_en,
  output logic                 o_main_osc_en,
  output logic                 o_timer_osc_en,
  output logic                 o_t2_sync_clk_en,
  output logic                 o_brownout_detector_en,
  output logic                 o_brownout_sleep_request,
  output logic                 o_adc_start,      // auto conversion pulse
  output logic                 o_adc_extended,   // next conversion long
  output logic                 o_comparator_off,
  output logic                 o_input_buf_off,
  output logic                 o_wdt_run,
  output logic                 o_sleeping,
  output logic [NPER-1:0]      o_periph_clk_en,
  output logic [NPER-1:0]      o_periph_reg_block
);
  typedef enum logic [1:0] {SPC_RUN, SPC_SLEEP, SPC_WAKE} spc_state_t;

  spc_state_t  st_q;           // controller state
  logic [2:0]  mode_q;         // latched sleep mode
  logic [2:0]  win_q;          // enable window left
  logic [2:0]  dly_q;          // cycles until request takes effect
  logic [2:0]  act_q;          // cycles request stays active
  logic [2:0]  act_d;          // next value of the active counter
  logic        req_q;          // registered request output
  logic        wdt_run_q;      // watchdog keeps running in sleep
  logic        bod_off_q;      // detector switched off for this sleep
  logic        adc_en_q;       // last adc enable level
  logic        adc_ext_q;      // extended conversion pending
  logic        adc_start_q;
  logic        cpu_q, flash_q, io_q, adcclk_q, asy_q, osc_q, tosc_q, t2s_q;
  logic        bod_en_q, cmp_off_q, ibuf_off_q, sleeping_q;
  logic [NPER-1:0] pclk_q;
  logic [15:0] wake_len;       // chosen wake-up delay
  logic        wake_done;      // wake delay over
  logic        wake_hit;       // permitted wake event this cycle
  logic        do_sleep;
  logic        legal_mode;
  logic [SPC_NWAKE-1:0] allow; // wake sources allowed in current mode

  // decoding of the mode and its clock domains
  function automatic logic is_pd_like(input logic [2:0] m);
    return (m == SPC_SEL_PDOWN) || (m == SPC_SEL_STBY);
  endfunction : is_pd_like
  function automatic logic is_ps_like(input logic [2:0] m);
    return (m == SPC_SEL_PSAVE) || (m == SPC_SEL_XSTBY);
  endfunction : is_ps_like

  // reserved codes and standby without crystal do not sleep
  assign legal_mode = (i_sleep_select_field <= SPC_SEL_PSAVE) ||
                      (i_ext_crystal &&
                       i_sleep_select_field >= SPC_SEL_STBY);
  assign do_sleep = (st_q == SPC_RUN) && i_sleep_instr && i_sleep_arm_bit
                    && legal_mode;

  // wake sources allowed in each mode
  always_comb begin
    allow = '0;
    allow[W_WDT] = 1'b1;
    allow[W_TWA] = 1'b1;
    allow[W_LVL] = 1'b1;
    allow[W_EXT] = 1'b1;
    allow[W_PCH] = 1'b1;
    unique case (mode_q)
      SPC_SEL_IDLE: allow = '1;
      SPC_SEL_ADCNR: begin
        allow[W_ADC] = 1'b1;
        allow[W_TWI] = 1'b1;
        allow[W_T2]  = 1'b1;
        allow[W_SPM] = 1'b1;
      end
      SPC_SEL_PDOWN, SPC_SEL_STBY: ;
      SPC_SEL_PSAVE, SPC_SEL_XSTBY:
        allow[W_T2] = i_t2_enable && i_t2_int_en && i_global_int_en;
      default: ;
    endcase
  end

  assign wake_hit = (st_q == SPC_SLEEP) &&
                    (i_reset_event || |(i_wake_src & allow));

  // wake delay: brown-out restart dominates, then oscillator start-up
  assign wake_len = bod_off_q ? 16'(BOD_WAKE_CYC) :
                    (mode_q == SPC_SEL_STBY || mode_q == SPC_SEL_XSTBY) ?
                      SPC_STBY_WAKE :
                    (is_pd_like(mode_q) || is_ps_like(mode_q)) ?
                      16'(STARTUP_CYC + SPC_HALT_EXTRA) :
                    SPC_HALT_EXTRA;

  spc_wake_timer #(.W(16)) u_wake (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_load    (wake_hit),
    .i_count   (wake_len),
    .o_done    (wake_done)
  );

  // next active count: loads as the delay runs out, then counts down.
  // the request output is registered from this value, so it rises on
  // the same edge as the counter and never glitches on the decode
  assign act_d = (dly_q == 3'h1) ? SPC_BROWNOUT_SLEEP_REQUEST_LEN :
                 (dly_q == 3'h0 && act_q != 3'h0) ? act_q - 3'h1 :
                 act_q;

  // timed sequence for the brown-out sleep request
  // an enable write opens a short window; a request write inside it
  // starts the delay, after which the request is active for a while.
  // a request write outside the window is ignored, so stray writes
  // of the request bit alone can never switch the detector off
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      win_q <= '0;
      dly_q <= '0;
      act_q <= '0;
      req_q <= 1'b0;
    end else begin
      if (win_q != 3'h0) win_q <= win_q - 3'h1;
      if (dly_q != 3'h0) dly_q <= dly_q - 3'h1;
      act_q <= act_d;
      req_q <= (act_d != 3'h0);
      if (i_ctrl_wr) begin
        if (i_ctrl_data[SPC_BROWNOUT_SLEEP_REQUEST_BIT] && i_ctrl_data[SPC_BROWNOUT_SLEEP_WRITE_ENABLE_BIT])
          win_q <= SPC_BROWNOUT_SLEEP_WRITE_ENABLE_WIN;
        else if (i_ctrl_data[SPC_BROWNOUT_SLEEP_REQUEST_BIT] && win_q != 3'h0) begin
          win_q <= '0;
          dly_q <= SPC_BROWNOUT_SLEEP_REQUEST_DLY;
        end
      end
    end
  end

  // main sleep state machine
  // run: waits for an armed sleep with a legal code.
  // sleep: clocks held off until an allowed wake source appears.
  // wake: clocks still held off while the wake timer runs, so the
  // detector settles before the core restarts; the oscillator keeps its sleep enable.
  // a reset event cuts the wake delay short and returns to run.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_q          <= SPC_RUN;
      mode_q        <= SPC_SEL_IDLE;
      bod_off_q     <= 1'b0;
    end else begin
      unique case (st_q)
        SPC_RUN: if (do_sleep) begin
          st_q      <= SPC_SLEEP;
          mode_q    <= i_sleep_select_field;
          // only deep modes permit the detector to be switched off
          bod_off_q <= (act_q != 3'h0) && i_brownout_fuse_en &&
                       (i_sleep_select_field >= SPC_SEL_PDOWN);
        end
        SPC_SLEEP: if (wake_hit) st_q <= SPC_WAKE;
        SPC_WAKE: if (wake_done || i_reset_event) begin
          st_q          <= SPC_RUN;
          bod_off_q     <= 1'b0;
        end
      endcase
    end
  end

  // clock domain enables per mode
  // the domains stay stopped through the wake delay as well; only
  // the detector comes back at once when the wake delay starts
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      {cpu_q, flash_q, io_q, adcclk_q, asy_q} <= 5'h1f;
      {osc_q, tosc_q, t2s_q, bod_en_q}        <= 4'hf;
      {cmp_off_q, ibuf_off_q, sleeping_q}     <= 3'h0;
    end else if (st_q != SPC_RUN) begin
      sleeping_q <= 1'b1;
      cpu_q      <= 1'b0;
      flash_q    <= 1'b0;
      io_q       <= (mode_q == SPC_SEL_IDLE);
      adcclk_q   <= (mode_q <= SPC_SEL_ADCNR);
      asy_q      <= (mode_q <= SPC_SEL_ADCNR) ||
                    (is_ps_like(mode_q) && i_t2_async);
      osc_q      <= (mode_q <= SPC_SEL_ADCNR) || mode_q[2] ||
                    i_debug_enable_fuse ||
                    (is_ps_like(mode_q) && !i_t2_async);
      tosc_q     <= i_t2_async && !is_pd_like(mode_q);
      t2s_q      <= i_t2_enable && !i_t2_async;
      bod_en_q   <= i_brownout_fuse_en &&
                    !(bod_off_q && st_q == SPC_SLEEP);
      cmp_off_q  <= (mode_q > SPC_SEL_ADCNR);
      ibuf_off_q <= (mode_q > SPC_SEL_ADCNR);
    end else begin
      sleeping_q <= 1'b0;
      {cpu_q, flash_q, io_q, adcclk_q, asy_q} <= 5'h1f;
      {osc_q, tosc_q, t2s_q}                  <= 3'h7;
      bod_en_q   <= i_brownout_fuse_en;
      cmp_off_q  <= 1'b0;
      ibuf_off_q <= 1'b0;
    end
  end

  // adc auto start and extended conversion tracking
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      adc_en_q    <= 1'b0;
      adc_ext_q   <= 1'b1;
      adc_start_q <= 1'b0;
    end else begin
      adc_en_q    <= i_adc_enable;
      adc_start_q <= do_sleep && i_adc_enable &&
                     (i_sleep_select_field <= SPC_SEL_ADCNR);
      if (i_adc_enable && !adc_en_q) adc_ext_q <= 1'b1;
      else if (adc_start_q) adc_ext_q <= 1'b0;
    end
  end

  // per-peripheral gates; a gated peripheral loses its clock and has its registers blocked
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) pclk_q <= '1;
    else pclk_q <= ~i_peripheral_clock_gate_register;
  end

  assign o_clk_cpu_en             = cpu_q;
  assign o_clk_flash_en           = flash_q;
  assign o_clk_io_en              = io_q;
  assign o_clk_adc_en             = adcclk_q;
  assign o_clk_asy_en             = asy_q;
  assign o_main_osc_en            = osc_q;
  assign o_timer_osc_en           = tosc_q;
  assign o_t2_sync_clk_en         = t2s_q;
  assign o_brownout_detector_en   = bod_en_q;
  assign o_brownout_sleep_request = req_q;
  assign o_adc_start              = adc_start_q;
  assign o_adc_extended           = adc_ext_q;
  assign o_comparator_off         = cmp_off_q;
  assign o_input_buf_off          = ibuf_off_q;
  assign o_wdt_run                = wdt_run_q;
  assign o_sleeping               = sleeping_q;
  assign o_periph_clk_en          = pclk_q;
  assign o_periph_reg_block       = ~pclk_q;

  // watchdog run flag ignores the sleep state entirely
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) wdt_run_q <= 1'b0;
    else wdt_run_q <= i_wdt_enable;
  end
endmodule : spc_sleep_ctrl
`default_nettype wire

//--- verilog/spc_wake_timer.sv
/*
 * spc_wake_timer: loadable down-counter that times the wake-up delay.
 * assumes: load and count in the one system clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module spc_wake_timer #(
  parameter int W = 16
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_srst,
  input  wire logic         i_load,    // start a new delay
  input  wire logic [W-1:0] i_count,   // delay length in cycles
  output logic              o_done     // one-cycle pulse at expiry
);
  logic [W-1:0] cnt_q;      // cycles left
  logic         run_q;      // counting
  logic         done_q;     // expiry pulse register

  assign o_done = done_q;

  // count down, pulse once the count is down to one
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (i_load) begin
        cnt_q <= i_count;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= W'(1)) begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule : spc_wake_timer
`default_nettype wire
